// ==== pmsm_pkg.sv ====
// Shared constants and types for the MII port, strap and LED block.
// Assumes a single 100 MHz core clock; every pin timing is derived from it.
package pmsm_pkg;

  // Core clock and synchroniser depth
  localparam int CLK_MHZ     = 100;            // Core clock rate in MHz
  localparam int SYNC_STAGES = 2;              // Flops in front of every pin input

  // LED flash after reset: time in ms, then the derived cycle count
  localparam int FLASH_MS  = 200;
  localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int FLASH_W   = 25;               // Wide enough for FLASH_CYC

  // Half periods of the generated link clock, in core cycles
  localparam logic [4:0] HALF_MII100 = 5'h02;  // 25 MHz nibble clock
  localparam logic [4:0] HALF_MII10  = 5'h14;  // 2.5 MHz nibble clock
  localparam logic [4:0] HALF_RMII   = 5'h01;  // 50 MHz reference rate
  localparam logic [4:0] HALF_SERIAL = 5'h05;  // 10 MHz bit clock

  // Transmit buffer shape: {error, nibble}
  localparam int FIFO_W = 5;
  localparam int FIFO_D = 32;

  // Layout of the synchronised pin vector
  localparam int PIN_W     = 10;
  localparam int PIN_RCVOE = 0;
  localparam int PIN_TXER  = 1;
  localparam int PIN_TXEN  = 2;
  localparam int PIN_TXD   = 3;               // Four bits from here
  localparam int PIN_STRAP = 7;               // Three bits from here

  // Reset values
  localparam logic [2:0] STRAP_RST = 3'h0;
  localparam logic [1:0] SETTLE_LAST = 2'h1;  // Cycles to fill the synchroniser, minus one

  // Pin mapping of the MAC side
  typedef enum logic [1:0] {
    PMSM_MII_NORMAL  = 2'h0,
    PMSM_MII_REDUCED = 2'h1,
    PMSM_MII_SERIAL  = 2'h3
  } pmsm_mii_e;

  // Media selection coded on the three straps, high bit first
  typedef enum logic [2:0] {
    PMSM_MED_DUAL_HDX  = 3'h0,
    PMSM_MED_FX_HDX    = 3'h1,
    PMSM_MED_FX_FDX    = 3'h2,
    PMSM_MED_10_HDX    = 3'h3,
    PMSM_MED_10_FDX    = 3'h4,
    PMSM_MED_TX_HDX    = 3'h5,
    PMSM_MED_TX_FDX    = 3'h6,
    PMSM_MED_AUTONEG   = 3'h7
  } pmsm_media_e;

  // Strap capture sequence after reset release
  typedef enum logic [1:0] {
    PMSM_ST_WAIT = 2'h0,
    PMSM_ST_CAPT = 2'h1,
    PMSM_ST_RUN  = 2'h3
  } pmsm_strap_e;

endpackage

// ==== pmsm_stream_if.sv ====
// Valid/ready word stream between the port logic and its buffer.
// Assumes producer and consumer share core_clk.
`timescale 1ns/1ns
interface pmsm_stream_if #(parameter int W = 5);
  logic         valid;  // Word offered
  logic         ready;  // Word can be taken
  logic [W-1:0] data;   // Word contents

  // Side that offers words
  modport producer (output valid, output data, input ready);
  // Side that takes words
  modport consumer (input valid, input data, output ready);
endinterface

// ==== pmsm_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides.
// Assumes both sides on core_clk; a word moves when valid and ready meet.
`timescale 1ns/1ns
module pmsm_fifo #(
  parameter int W = 5,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          nrst,
  // Filling and draining sides
  pmsm_stream_if.consumer   wr,
  pmsm_stream_if.producer   rd
);
  import pmsm_pkg::*;

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];       // Storage flops
  logic [AW:0]  wr_ptr_q;        // Write pointer with wrap bit
  logic [AW:0]  rd_ptr_q;        // Read pointer with wrap bit
  logic         full;            // No room left
  logic         empty;           // Nothing stored
  logic         do_wr;           // Word enters this cycle
  logic         do_rd;           // Word leaves this cycle

  // Full when pointers differ only in the wrap bit
  assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_q[rd_ptr_q[AW-1:0]];
  assign do_wr = wr.valid && !full;
  assign do_rd = rd.ready && !empty;

  // Storage write; no reset needed on the data itself
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr.data;
    end
  end

  // Pointer update
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule

// ==== pmsm_port.sv ====
// MAC-facing port of the transceiver: MII pin mappings, straps and LEDs.
// Assumes the line coder sits behind the line_* streams on the same clock,
// and that the MAC drives its pins off the clocks generated here.
`timescale 1ns/1ns
module pmsm_port #(
  parameter int FLASH_CYCLES = pmsm_pkg::FLASH_CYC  // Shorten for simulation
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // Mode and control
  input  wire pmsm_pkg::pmsm_mii_e  mii_mode,
  input  wire logic                 link_speed100,
  input  wire logic                 sw_reset_pulse,
  input  wire logic [2:0]           led_state,
  input  wire logic                 tx_ovf_clr,
  // Strap and LED pins, bit 0 is media_select_strap_bit0
  input  wire logic [2:0]           strap_led_in,
  output logic      [2:0]           strap_led_out,
  output logic      [2:0]           strap_led_oe,
  // Configuration latched from the straps, except cfg_refclk_50m from mii_mode and cfg_speed100 from link_speed100 in the dual and autoneg codes
  output pmsm_pkg::pmsm_media_e     cfg_media,
  output logic                      cfg_valid,
  output logic                      cfg_autoneg,
  output logic                      cfg_speed100,
  output logic                      cfg_full_duplex,
  output logic                      cfg_fiber,
  output logic                      cfg_refclk_50m,
  // MII transmit pins
  output logic                      tx_clk,
  input  wire logic [3:0]           txd,
  input  wire logic                 tx_en,
  input  wire logic                 tx_er,
  // MII receive pins
  input  wire logic                 receive_output_enable,
  output logic                      rx_clk,
  output logic      [3:0]           rxd,
  output logic                      rx_dv,
  output logic                      rx_er,
  output logic                      rx_oe,
  output logic                      col,
  output logic                      crs,
  // Line side, transmit words {error, nibble}
  output logic                      line_tx_valid,
  input  wire logic                 line_tx_ready,
  output logic      [4:0]           line_tx_data,
  // Line side, receive nibbles
  input  wire logic                 line_rx_valid,
  output logic                      line_rx_ready,
  input  wire logic [3:0]           line_rx_data,
  input  wire logic                 line_rx_err,
  input  wire logic                 line_rx_active,
  // Status
  output logic                      tx_overflow
);
  import pmsm_pkg::*;

  // Pin synchroniser
  logic [PIN_W-1:0] pin_raw;       // All asynchronous pin inputs
  logic [PIN_W-1:0] sync1_q;       // First stage, read only by the second
  logic [PIN_W-1:0] sync2_q;       // Safe to use
  logic             rcv_oe_s;      // Receive outputs enabled
  logic             txer_s;        // Synchronised transmit error
  logic             txen_s;        // Synchronised transmit enable
  logic [3:0]       txd_s;         // Synchronised transmit data
  logic [2:0]       strap_s;       // Synchronised strap levels

  // Strap capture and LEDs
  pmsm_strap_e      st_q;          // Capture sequence state
  logic [1:0]       settle_q;      // Synchroniser fill count
  logic [2:0]       strap_q;       // Latched strap levels
  logic [FLASH_W-1:0] flash_q;     // Remaining flash cycles
  logic [2:0]       led_q;         // LED pin levels

  // Link clock generator
  logic [4:0]       half;          // Half period for this mode
  logic [4:0]       div_q;         // Half period counter
  logic             lclk_q;        // Generated link clock
  logic             rise;          // Link clock rises this cycle
  logic             fall;          // Link clock falls this cycle
  logic [1:0]       rise_dly_q;    // Rise delayed to match the synchroniser
  logic             tx_take;       // Pin values of the last rising edge are here

  // Transmit assembly
  logic [1:0]       last_beat;     // Beats per nibble minus one
  logic [3:0]       rx_mask;       // Receive pins used in this mode
  logic [3:0]       tx_acc_q;      // Nibble being assembled
  logic [3:0]       tx_acc_d;
  logic             tx_er_q;       // Error seen within the nibble
  logic             tx_er_d;
  logic [1:0]       tx_cnt_q;      // Beats collected
  logic             tx_push;       // Complete nibble to the buffer
  logic             ovf_q;         // Sticky: nibble lost on a full buffer

  // Receive serialiser
  logic [1:0]       rx_cnt_q;      // Beats still to send of this nibble
  logic [3:0]       rx_rem_q;      // Bits not yet on the pins
  logic [3:0]       rxd_q;         // Receive data pins
  logic             dv_q;          // Frame data valid
  logic             rx_er_q;       // Receive error
  logic             rx_dv_q;       // Valid pin, mode mapped
  logic             crs_q;         // Carrier sense
  logic             col_q;         // Collision
  logic             rcv_oe_q;      // Receive output enable

  pmsm_stream_if #(.W(FIFO_W)) tx_wr ();
  pmsm_stream_if #(.W(FIFO_W)) tx_rd ();

  // Two flops on every pin before use
  assign pin_raw = {strap_led_in, txd, tx_en, tx_er, receive_output_enable};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end
  assign rcv_oe_s = sync2_q[PIN_RCVOE];
  assign txer_s   = sync2_q[PIN_TXER];
  assign txen_s   = sync2_q[PIN_TXEN];
  assign txd_s    = sync2_q[PIN_TXD +: 4];
  assign strap_s  = sync2_q[PIN_STRAP +: 3];

  // Strap capture: pins stay undriven through reset and until latched
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= PMSM_ST_WAIT;
      settle_q <= '0;
      strap_q  <= STRAP_RST;
    end else begin
      case (st_q)
        PMSM_ST_WAIT: begin
          // Synchroniser still holds its reset value
          settle_q <= settle_q + 1'b1;
          if (settle_q == SETTLE_LAST) begin
            st_q <= PMSM_ST_CAPT;
          end
        end
        PMSM_ST_CAPT: begin
          strap_q <= strap_s;
          st_q    <= PMSM_ST_RUN;
        end
        PMSM_ST_RUN: begin
          st_q <= PMSM_ST_RUN;
        end
        default: begin
          st_q <= PMSM_ST_WAIT;
        end
      endcase
    end
  end

  // Decode the latched media code
  always_comb begin
    cfg_media       = pmsm_media_e'(strap_q);
    cfg_valid       = (st_q == PMSM_ST_RUN);
    cfg_autoneg     = 1'b0;
    cfg_speed100    = 1'b1;
    cfg_full_duplex = 1'b0;
    cfg_fiber       = 1'b0;
    case (cfg_media)
      PMSM_MED_DUAL_HDX: cfg_speed100 = link_speed100;
      PMSM_MED_FX_HDX:   cfg_fiber = 1'b1;
      PMSM_MED_FX_FDX: begin
        cfg_fiber       = 1'b1;
        cfg_full_duplex = 1'b1;
      end
      PMSM_MED_10_HDX:   cfg_speed100 = 1'b0;
      PMSM_MED_10_FDX: begin
        cfg_speed100    = 1'b0;
        cfg_full_duplex = 1'b1;
      end
      PMSM_MED_TX_HDX:   cfg_speed100 = 1'b1;
      PMSM_MED_TX_FDX:   cfg_full_duplex = 1'b1;
      PMSM_MED_AUTONEG: begin
        cfg_autoneg     = 1'b1;
        cfg_speed100    = link_speed100;
        cfg_full_duplex = 1'b1;
      end
      default: cfg_speed100 = 1'b1;
    endcase
  end

  // Reduced mode runs from an outside 50 MHz reference, not the crystal
  assign cfg_refclk_50m = (mii_mode == PMSM_MII_REDUCED);

  // Flash timer, reloaded on capture and on every software reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_q <= '0;
    end else if (st_q == PMSM_ST_CAPT || sw_reset_pulse) begin
      flash_q <= FLASH_W'(FLASH_CYCLES - 1);
    end else if (flash_q != '0) begin
      flash_q <= flash_q - 1'b1;
    end
  end

  // LED level: active state inverted against the strap, pins driven after capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      led_q        <= '0;
      strap_led_oe <= '0;
    end else begin
      led_q        <= strap_q ^ (led_state | {3{flash_q != '0}});
      strap_led_oe <= {3{st_q == PMSM_ST_RUN}};
    end
  end
  assign strap_led_out = led_q;

  // Link clock rate follows pin map and speed
  always_comb begin
    case (mii_mode)
      PMSM_MII_REDUCED: half = HALF_RMII;
      PMSM_MII_SERIAL:  half = HALF_SERIAL;
      default:          half = cfg_speed100 ? HALF_MII100 : HALF_MII10;
    endcase
  end

  // Free-running divider; never gated, so both clocks stay continuous
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q  <= '0;
      lclk_q <= 1'b0;
    end else if (div_q >= half - 5'h01) begin
      div_q  <= '0;
      lclk_q <= !lclk_q;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end
  assign rise   = (div_q >= half - 5'h01) && !lclk_q;
  assign fall   = (div_q >= half - 5'h01) && lclk_q;
  assign tx_clk = lclk_q;
  assign rx_clk = lclk_q;

  // Delay the rising edge by the synchroniser depth so the sampled pins match it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rise_dly_q <= '0;
    end else begin
      rise_dly_q <= {rise_dly_q[0], rise};
    end
  end
  assign tx_take = rise_dly_q[1];

  // Beats per nibble and live receive pins for each pin map
  always_comb begin
    case (mii_mode)
      PMSM_MII_REDUCED: begin
        last_beat = 2'h1;
        rx_mask   = 4'h3;
      end
      PMSM_MII_SERIAL: begin
        last_beat = 2'h3;
        rx_mask   = 4'h1;
      end
      default: begin
        last_beat = 2'h0;
        rx_mask   = 4'hF;
      end
    endcase
  end

  // Next assembled nibble; low bits arrive first in the narrow maps
  always_comb begin
    case (mii_mode)
      PMSM_MII_REDUCED: tx_acc_d = {txd_s[1:0], tx_acc_q[3:2]};
      PMSM_MII_SERIAL:  tx_acc_d = {txd_s[0], tx_acc_q[3:1]};
      default:          tx_acc_d = txd_s;
    endcase
    tx_er_d = txer_s || (tx_er_q && tx_cnt_q != 2'h0);
  end

  // Collect beats while enable is high; a dropped enable discards a part nibble
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_acc_q <= '0;
      tx_er_q  <= 1'b0;
      tx_cnt_q <= '0;
    end else if (tx_take) begin
      if (txen_s) begin
        tx_acc_q <= tx_acc_d;
        tx_er_q  <= tx_er_d;
        tx_cnt_q <= (tx_cnt_q == last_beat) ? 2'h0 : tx_cnt_q + 2'h1;
      end else begin
        tx_er_q  <= 1'b0;
        tx_cnt_q <= '0;
      end
    end
  end

  // The MAC cannot be stalled, so a full buffer loses the nibble and flags it
  assign tx_push      = tx_take && txen_s && (tx_cnt_q == last_beat);
  assign tx_wr.valid  = tx_push;
  assign tx_wr.data   = {tx_er_d, tx_acc_d};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
    end else if (tx_push && !tx_wr.ready) begin
      ovf_q <= 1'b1;  // Set wins over clear
    end else if (tx_ovf_clr) begin
      ovf_q <= 1'b0;
    end
  end
  assign tx_overflow = ovf_q;

  pmsm_fifo #(.W(FIFO_W), .D(FIFO_D)) u_tx_fifo (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr       (tx_wr.consumer),
    .rd       (tx_rd.producer)
  );
  assign line_tx_valid = tx_rd.valid;
  assign line_tx_data  = tx_rd.data;
  assign tx_rd.ready   = line_tx_ready;

  // Receive nibbles are taken only at a falling edge once no beats of the last nibble are left to send
  assign line_rx_ready = fall && (rx_cnt_q == 2'h0);

  // Drive receive pins at the falling edge so the MAC samples them settled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_q <= '0;
      rx_rem_q <= '0;
      rxd_q    <= '0;
      dv_q     <= 1'b0;
      rx_er_q  <= 1'b0;
    end else if (fall) begin
      if (rx_cnt_q != 2'h0) begin
        rxd_q    <= rx_rem_q & rx_mask;
        rx_rem_q <= (mii_mode == PMSM_MII_SERIAL) ? rx_rem_q >> 1 : rx_rem_q >> 2;
        rx_cnt_q <= rx_cnt_q - 2'h1;
      end else if (line_rx_valid) begin
        rxd_q    <= line_rx_data & rx_mask;
        rx_rem_q <= (mii_mode == PMSM_MII_SERIAL) ? line_rx_data >> 1 : line_rx_data >> 2;
        rx_cnt_q <= last_beat;
        dv_q     <= 1'b1;
        rx_er_q  <= line_rx_err;
      end else begin
        // Gap in the stream ends the frame before any end delimiter
        rxd_q   <= '0;
        dv_q    <= 1'b0;
        rx_er_q <= 1'b0;
      end
    end
  end

  // Carrier, collision, mapped valid pin and output enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crs_q    <= 1'b0;
      col_q    <= 1'b0;
      rx_dv_q  <= 1'b0;
      rcv_oe_q <= 1'b0;
    end else begin
      crs_q    <= txen_s || line_rx_active || dv_q;
      col_q    <= txen_s && line_rx_active && !cfg_full_duplex;
      rcv_oe_q <= rcv_oe_s;
      case (mii_mode)
        PMSM_MII_REDUCED: rx_dv_q <= dv_q || crs_q;
        PMSM_MII_SERIAL:  rx_dv_q <= 1'b0;
        default:          rx_dv_q <= dv_q;
      endcase
    end
  end
  assign rxd   = rxd_q;
  assign rx_dv = rx_dv_q;
  assign rx_er = rx_er_q;
  assign rx_oe = rcv_oe_q;
  assign crs   = crs_q;
  assign col   = col_q;
endmodule

// ==== pmsm_port_props.sv ====
// Concurrent checks on the pins of the MII port, strap and LED block.
// Assumes only the top ports of pmsm_port; bound into every instance below.
`timescale 1ns/1ns
module pmsm_port_props (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 nrst,
  // Mode, straps and configuration
  input wire pmsm_pkg::pmsm_mii_e   mii_mode,
  input wire logic [2:0]           strap_led_oe,
  input wire pmsm_pkg::pmsm_media_e cfg_media,
  input wire logic                 cfg_valid,
  input wire logic                 cfg_fiber,
  input wire logic                 cfg_refclk_50m,
  // Link clock and receive pins
  input wire logic                 tx_clk,
  input wire logic                 receive_output_enable,
  input wire logic                 rx_oe,
  input wire logic [3:0]           rxd,
  input wire logic                 rx_dv,
  input wire logic                 crs,
  // Line side receive stream
  input wire logic                 line_rx_valid,
  input wire logic                 line_rx_ready,
  input wire logic [3:0]           line_rx_data,
  input wire logic                 line_rx_active
);
  import pmsm_pkg::*;
  // One clock domain, so clocking and reset are stated once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // A nibble taken from the line in nibble mode
  sequence s_take;
    line_rx_ready && line_rx_valid && mii_mode == PMSM_MII_NORMAL;
  endsequence
  // Nibble shows next cycle, valid pin one cycle after that
  sequence s_show;
    rxd == $past(line_rx_data) ##1 rx_dv;
  endsequence
  property p_rx_take;
    s_take |=> s_show;
  endproperty
  a_rx_take: assert property (p_rx_take) else $error("rx nibble not presented");
  // Slowest half period is 20 cycles, so a level lasting 40 means a stopped clock
  property p_txclk_run;
    $rose(tx_clk) |-> ##[1:40] $fell(tx_clk);
  endproperty
  a_txclk_run: assert property (p_txclk_run) else $error("tx clock stalled");
  property p_crs;
    line_rx_active |=> crs;
  endproperty
  a_crs: assert property (p_crs) else $error("carrier sense missing");
  property p_media_stable;
    cfg_valid && $past(cfg_valid) |-> $stable(cfg_media);
  endproperty
  a_media_stable: assert property (p_media_stable) else $error("latched media moved");
  property p_oe_rise;
    $rose(cfg_valid) |-> ##[0:2] strap_led_oe == 3'h7;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("strap pins not driven");
  property p_fiber;
    cfg_valid |-> cfg_fiber == (cfg_media inside {PMSM_MED_FX_HDX, PMSM_MED_FX_FDX});
  endproperty
  a_fiber: assert property (p_fiber) else $error("fiber decode wrong");
  property p_refclk;
    cfg_refclk_50m == (mii_mode == PMSM_MII_REDUCED);
  endproperty
  a_refclk: assert property (p_refclk) else $error("reference clock flag wrong");
  // Synchroniser plus register settle well inside six cycles
  property p_rx_float;
    $stable(receive_output_enable) [*6] |-> rx_oe == receive_output_enable;
  endproperty
  a_rx_float: assert property (p_rx_float) else $error("rx drive not following enable");
endmodule

bind pmsm_port pmsm_port_props i_props (.core_clk, .nrst, .mii_mode, .strap_led_oe,
  .cfg_media, .cfg_valid, .cfg_fiber, .cfg_refclk_50m, .tx_clk, .receive_output_enable,
  .rx_oe, .rxd, .rx_dv, .crs, .line_rx_valid, .line_rx_ready, .line_rx_data, .line_rx_active);

// ==== pmsm_mac_model.sv ====
// Transmit side of the MAC: one beat per rising link clock.
// Assumes tx_clk comes from the port and core_clk is the port's clock.
`timescale 1ns/1ns
module pmsm_mac_model (
  // Clocks
  input  wire logic       core_clk,
  input  wire logic       tx_clk,
  // Transmit pins
  output logic      [3:0] txd,
  output logic            tx_en,
  output logic            tx_er
);
  // Idle at time zero
  initial begin
    txd   = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end
  // Change just after a rise, hold to the next rise
  task automatic beat(input logic [3:0] d, input logic er);
    @(posedge tx_clk);
    @(negedge core_clk);
    txd   = d;
    tx_en = 1'b1;
    tx_er = er;
  endtask
  // Released data flips so a stale beat can never look valid
  task automatic idle();
    @(posedge tx_clk);
    @(negedge core_clk);
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd   = ~txd;
  endtask
endmodule

// ==== tb_pmsm_port.sv ====
// Self-checking bench for the MII port, strap and LED block.
// Assumes the MAC model on the transmit pins; the bench plays the line side.
`timescale 1ns/1ns
module tb_pmsm_port;
  import pmsm_pkg::*;
  localparam int FL = 50;                           // Short LED flash
  logic core_clk = 0, nrst = 0, link_speed100 = 1, sw_reset_pulse = 0, tx_ovf_clr = 0;
  logic [2:0] strap = 0, led_state = 0, strap_led_out, strap_led_oe;
  wire  [2:0] strap_led_in;
  pmsm_mii_e mii_mode = PMSM_MII_NORMAL;
  pmsm_media_e cfg_media;
  logic cfg_valid, cfg_speed100, cfg_full_duplex, tx_clk, tx_en, tx_er, rx_dv, rx_er;
  logic cfg_autoneg, rx_clk, col;
  logic [3:0] txd, rxd, line_rx_data = 0;
  logic receive_output_enable = 1, rx_oe, crs, line_tx_valid, line_tx_ready = 0;
  logic [4:0] line_tx_data;
  logic line_rx_valid = 0, line_rx_ready, line_rx_err = 0, line_rx_active = 0, tx_overflow;
  int mismatches = 0, n_tests = 0, cyc = 0;
  // Pin level: the port once enabled, else the strap pull
  assign strap_led_in = (strap_led_oe & strap_led_out) | (~strap_led_oe & strap);
  always #5 core_clk = ~core_clk;
  pmsm_port #(.FLASH_CYCLES(FL)) i_dut (.core_clk, .nrst, .mii_mode, .link_speed100,
    .sw_reset_pulse, .led_state, .tx_ovf_clr, .strap_led_in, .strap_led_out, .strap_led_oe,
    .cfg_media, .cfg_valid, .cfg_autoneg, .cfg_speed100, .cfg_full_duplex, .cfg_fiber(),
    .cfg_refclk_50m(), .tx_clk, .txd, .tx_en, .tx_er, .receive_output_enable, .rx_clk,
    .rxd, .rx_dv, .rx_er, .rx_oe, .col, .crs, .line_tx_valid, .line_tx_ready, .line_tx_data,
    .line_rx_valid, .line_rx_ready, .line_rx_data, .line_rx_err, .line_rx_active, .tx_overflow);
  pmsm_mac_model i_mac (.core_clk, .tx_clk, .txd, .tx_en, .tx_er);
  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic do_reset(input logic [2:0] c);
    @(negedge core_clk);
    nrst = 0;
    strap = c;
    repeat (12) @(negedge core_clk);
    nrst = 1;
    repeat (6) @(negedge core_clk);
  endtask
  // Every strap code, both polarities of the LEDs, flash on both resets
  task automatic t_straps();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      link_speed100 = c[0];
      do_reset(c);
      chk(cfg_media === pmsm_media_e'(c) && cfg_valid === 1'b1, "media latch");
      chk(cfg_full_duplex === (c inside {3'h2, 3'h4, 3'h6, 3'h7}), "duplex");
      chk(cfg_speed100 === (c inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}), "speed");
      chk(cfg_autoneg === (c == 3'h7), "autoneg");
      chk(strap_led_oe === 3'h7 && strap_led_out === ~c, "flash");
      strap = ~c;
      repeat (FL + 10) @(negedge core_clk);
      chk(strap_led_out === c && cfg_media === pmsm_media_e'(c), "led dark");
      led_state = 3'h5;
      repeat (3) @(negedge core_clk);
      chk(strap_led_out === (c ^ 3'h5), "led lit");
      led_state = 3'h0;
      // Both media busy: collision only in half duplex; next reset empties the buffer
      if (c != 3'h7) begin
        line_rx_active = 1;
        i_mac.beat(4'h0, 1'b0);
        repeat (4) @(negedge core_clk);
        chk(col === !(c inside {3'h2, 3'h4, 3'h6}), "collision");
        i_mac.idle();
        line_rx_active = 0;
      end
    end
    sw_reset_pulse = 1;
    @(negedge core_clk);
    sw_reset_pulse = 0;
    repeat (3) @(negedge core_clk);
    chk(strap_led_out === ~c, "soft flash");
    repeat (FL + 10) @(negedge core_clk);
  endtask
  // Nibbles in beats of k bits, line stalled; drained in order afterwards
  task automatic t_tx(input pmsm_mii_e m, input int n, input int k);
    logic [4:0] exp[$];
    logic [3:0] d;
    logic er;
    mii_mode = m;
    for (int j = 0; j < n; j++) begin
      d = j[3:0] ^ 4'hA;
      er = (k == 4 && j == 1);
      if (j < 32) exp.push_back({er, d});
      for (int b = 0; b < 4; b += k) i_mac.beat((d >> b) & ((1 << k) - 1), er);
    end
    i_mac.idle();
    repeat (8) @(negedge core_clk);
    chk(tx_overflow === (n > 32), "overflow");
    line_tx_ready = 1;
    while (exp.size() > 0) begin
      if (line_tx_valid === 1'b1) chk(line_tx_data === exp.pop_front(), "tx word");
      @(negedge core_clk);
    end
    @(negedge core_clk);
    chk(line_tx_valid === 1'b0, "not empty");
    line_tx_ready = 0;
    tx_ovf_clr = 1;
    @(negedge core_clk);
    tx_ovf_clr = 0;
  endtask
  // Receive frame with one errored nibble, frame end, carrier, float
  task automatic t_rx();
    mii_mode = PMSM_MII_NORMAL;
    line_rx_active = 1;
    for (int j = 0; j < 5; j++) begin
      line_rx_valid = (j < 4);
      line_rx_data = 4'h3 + j[3:0];
      line_rx_err = (j == 2);
      while (line_rx_ready !== 1'b1) @(negedge core_clk);
      @(posedge core_clk);
      #1 chk(rxd === (j < 4 ? line_rx_data : 4'h0) && rx_er === (j == 2), "rx nibble");
      @(posedge core_clk);
      #1 chk(rx_dv === (j < 4) && crs === 1'b1, "rx valid");
      @(negedge core_clk);
    end
    line_rx_active = 0;
    repeat (4) @(negedge core_clk);
    chk(crs === 1'b0, "carrier idle");
    chk(rx_clk === tx_clk, "rx clock");
    receive_output_enable = 0;
    repeat (8) @(negedge core_clk);
    chk(rx_oe === 1'b0, "rx float");
    receive_output_enable = 1;
    repeat (6) @(negedge core_clk);
    chk(rx_oe === 1'b1, "rx drive");
    // Reduced map: one nibble as two dibits, low first, valid pin follows carrier
    mii_mode = PMSM_MII_REDUCED;
    @(negedge core_clk);
    line_rx_valid = 1;
    line_rx_data = 4'h9;
    while (line_rx_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    #1 chk(rxd === 4'h1, "rmii low dibit");
    @(negedge core_clk);
    line_rx_valid = 0;
    repeat (2) @(posedge core_clk);
    #1 chk(rxd === 4'h2 && rx_dv === 1'b1, "rmii high dibit");
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_straps();
    t_tx(PMSM_MII_NORMAL, 34, 4);
    t_tx(PMSM_MII_REDUCED, 3, 2);
    t_tx(PMSM_MII_SERIAL, 3, 1);
    t_rx();
    close_out();
  end
endmodule
